// ===== hdl/sfs_status_bank.sv
// Operation
// RL1: Input a polarity 0 low faults, 1 high
// RL2: Input b polarity 0 low faults, 1 high
// RL3: Pair polarity picks which complementary levels fault
// RL4: Pair mode bit selects independent or paired judging
// RL5: Config field applies only when inverse copy matches
// RL6: Closed-window answer or timeout sets timing error
// RL7: Wrong watchdog answer data sets answer error
// RL8: Bus write checksum mismatch sets checksum error
// RL9: Live thermal bit follows thermal shutdown condition
// RL10: Live current-limit bits follow both regulators
// RL11: Live overvoltage bits follow each monitored supply
// RL12: Latched flags set on condition, hold until cleared
// RL13: Undervoltage bits report undervoltage, one means detected
`timescale 1ns/1ns
module sfs_status_bank
   import sfs_pkg::*;
(
   input wire logic CLOCK_I, // 125 MHz clock
   input wire logic SYS_RST_I, // Synchronous reset, high
   input wire logic [2:0] REG_ADDR_I, // Register index
   input wire logic REG_WR_I, // Write strobe
   input wire logic [15:0] REG_WDATA_I, // Write data
   input wire logic REG_RD_I, // Read strobe
   output logic [15:0] REG_RDATA_O, // Read data
   output logic REG_RVALID_O, // Read data valid pulse
   input wire logic FAULT_INPUT_A_I, // First fault input level
   input wire logic FAULT_INPUT_B_I, // Second fault input level
   input wire logic [5:0] OVER_LIVE_I, // Overvoltage: mon1..4, reg1, reg2
   input wire logic [5:0] UNDER_LIVE_I, // Undervoltage: mon1..4, reg1, reg2
   input wire logic [1:0] CURLIMIT_LIVE_I, // Current limit: reg1, reg2
   input wire logic THERMAL_LIVE_I, // Thermal shutdown present
   input wire logic ERR_MON_ONE_I, // Error monitor one event
   input wire logic ERR_MON_TWO_I, // Error monitor two event
   input wire logic WDOG_CLOSED_WRITE_I, // Answer written in closed window
   input wire logic WDOG_TIMEOUT_I, // Refresh timed out
   input wire logic WDOG_BAD_ANSWER_I, // Refresh carried wrong data
   input wire logic BUS_CRC_ERR_I, // Checksum mismatch on a bus write
   input wire logic BUS_REQ_ERR_I, // Bad bus request
   output logic FAULT_ACTIVE_O // Fault input judged faulty now
);

   logic [15:0] supply_fault_latched;
   logic [15:0] supply_fault_live;
   logic [15:0] input_watchdog_bus_errors;
   logic [15:0] fault_input_config;
   logic [15:0] fault_input_config_inv;
   logic [15:0] cfg_applied;
   logic [15:0] next_supply_fault_latched;
   logic [15:0] next_errors;
   logic [15:0] next_applied;
   logic [15:0] live_now;
   logic [15:0] error_events;
   logic [15:0] read_mux;
   logic [15:0] field_match;
   logic wr_supply, wr_errors, wr_config, wr_config_inv;
   logic input_a_polarity, input_b_polarity, pair_polarity, pair_mode_select;
   logic input_a_fault, input_b_fault, pair_fault;
   logic input_a_error, input_b_error, pair_error;

   // Address decode of write strobes
   assign wr_supply = REG_WR_I && (REG_ADDR_I == SFS_REG_SUPPLY_LATCHED);
   assign wr_errors = REG_WR_I && (REG_ADDR_I == SFS_REG_ERRORS);
   assign wr_config = REG_WR_I && (REG_ADDR_I == SFS_REG_CONFIG);
   assign wr_config_inv = REG_WR_I && (REG_ADDR_I == SFS_REG_CONFIG_INV);

   // Live supply view; undervoltage lanes carry undervoltage, not overvoltage
   assign live_now = {1'b0, CURLIMIT_LIVE_I, THERMAL_LIVE_I, // see RL9 see RL10
                      UNDER_LIVE_I, OVER_LIVE_I}; // see RL11 see RL13

   // A field is applied only when its inverse copy is its exact complement
   assign field_match = fault_input_config ^ fault_input_config_inv; // see RL5
   assign next_applied = (field_match & SFS_CONFIG_MASK & fault_input_config)
                         | (~(field_match & SFS_CONFIG_MASK) & cfg_applied); // see RL5

   assign input_a_polarity = cfg_applied[SFS_POL_A_BIT];
   assign input_b_polarity = cfg_applied[SFS_POL_B_BIT];
   assign pair_polarity = cfg_applied[SFS_PAIR_POL_BIT];
   assign pair_mode_select = cfg_applied[SFS_PAIR_MODE_BIT];

   // Fault judgement; a level equal to the polarity bit is the fault level
   assign input_a_fault = (FAULT_INPUT_A_I == input_a_polarity); // see RL1
   assign input_b_fault = (FAULT_INPUT_B_I == input_b_polarity); // see RL2
   assign pair_fault = pair_polarity ? (FAULT_INPUT_A_I || !FAULT_INPUT_B_I)
                                     : (!FAULT_INPUT_A_I || FAULT_INPUT_B_I); // see RL3
   assign input_a_error = !pair_mode_select && input_a_fault; // see RL4
   assign input_b_error = !pair_mode_select && input_b_fault; // see RL4
   assign pair_error = pair_mode_select && pair_fault; // see RL4

   // Error events gathered into their register lanes
   always_comb begin
      error_events = SFS_ZERO;
      error_events[SFS_INPUT_A_ERR_BIT] = input_a_error;
      error_events[SFS_INPUT_B_ERR_BIT] = input_b_error;
      error_events[SFS_PAIR_ERR_BIT] = pair_error;
      error_events[SFS_ERR_MON_ONE_BIT] = ERR_MON_ONE_I;
      error_events[SFS_ERR_MON_TWO_BIT] = ERR_MON_TWO_I;
      error_events[SFS_WDOG_TIMING_BIT] = WDOG_CLOSED_WRITE_I || WDOG_TIMEOUT_I; // see RL6
      error_events[SFS_WDOG_ANSWER_BIT] = WDOG_BAD_ANSWER_I; // see RL7
      error_events[SFS_CRC_ERR_BIT] = BUS_CRC_ERR_I; // see RL8
      error_events[SFS_REQ_ERR_BIT] = BUS_REQ_ERR_I;
   end

   // Write one to clear, but a new event in the same cycle wins over the clear
   assign next_supply_fault_latched = (supply_fault_latched & ~(wr_supply ? REG_WDATA_I : SFS_ZERO))
                                      | live_now; // see RL12
   assign next_errors = (input_watchdog_bus_errors & ~(wr_errors ? REG_WDATA_I : SFS_ZERO))
                        | error_events; // see RL6 see RL7 see RL8

   // Read selection; unmapped indices read as zero
   assign read_mux = (REG_ADDR_I == SFS_REG_SUPPLY_LATCHED) ? supply_fault_latched :
                     (REG_ADDR_I == SFS_REG_SUPPLY_LIVE) ? supply_fault_live :
                     (REG_ADDR_I == SFS_REG_ERRORS) ? input_watchdog_bus_errors :
                     (REG_ADDR_I == SFS_REG_CONFIG) ? fault_input_config :
                     (REG_ADDR_I == SFS_REG_CONFIG_INV) ? fault_input_config_inv : SFS_ZERO;

   // Status flags; live copy is one flop behind its inputs
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         supply_fault_latched <= SFS_ZERO;
         supply_fault_live <= SFS_ZERO;
         input_watchdog_bus_errors <= SFS_ZERO;
      end else begin
         supply_fault_latched <= next_supply_fault_latched;
         supply_fault_live <= live_now; // see RL9 see RL10 see RL11
         input_watchdog_bus_errors <= next_errors;
      end
   end

   // Configuration pair and the copy that the judgement actually uses
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         fault_input_config <= SFS_CONFIG_RESET;
         fault_input_config_inv <= SFS_CONFIG_INV_RESET;
         cfg_applied <= SFS_CONFIG_RESET;
      end else begin
         if (wr_config) begin
            fault_input_config <= REG_WDATA_I & SFS_CONFIG_MASK;
         end
         if (wr_config_inv) begin
            fault_input_config_inv <= REG_WDATA_I & SFS_CONFIG_MASK;
         end
         cfg_applied <= next_applied; // see RL5
      end
   end

   // Read port and fault indicator, all registered
   always_ff @(posedge CLOCK_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O <= SFS_ZERO;
         REG_RVALID_O <= 1'b0;
         FAULT_ACTIVE_O <= 1'b0;
      end else begin
         REG_RDATA_O <= REG_RD_I ? read_mux : REG_RDATA_O;
         REG_RVALID_O <= REG_RD_I;
         FAULT_ACTIVE_O <= input_a_error || input_b_error || pair_error;
      end
   end

   // Checks of flag behaviour against the inputs that cause it
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (SYS_RST_I);

   property p_input_a_low;
      (!pair_mode_select && !input_a_polarity && !FAULT_INPUT_A_I)
         |=> input_watchdog_bus_errors[SFS_INPUT_A_ERR_BIT] && FAULT_ACTIVE_O;
   endproperty
   a_input_a_low: assert property (p_input_a_low) else $error("input a low fault not flagged"); // see RL1

   property p_input_b_high;
      (!pair_mode_select && input_b_polarity && FAULT_INPUT_B_I)
         |=> input_watchdog_bus_errors[SFS_INPUT_B_ERR_BIT];
   endproperty
   a_input_b_high: assert property (p_input_b_high) else $error("input b high fault not flagged"); // see RL2

   property p_pair_fault;
      (pair_mode_select && !pair_polarity && (!FAULT_INPUT_A_I || FAULT_INPUT_B_I))
         |=> input_watchdog_bus_errors[SFS_PAIR_ERR_BIT];
   endproperty
   a_pair_fault: assert property (p_pair_fault) else $error("pair fault not flagged"); // see RL3

   property p_pair_quiet;
      (pair_mode_select && !pair_polarity && FAULT_INPUT_A_I && !FAULT_INPUT_B_I)
         |=> !FAULT_ACTIVE_O;
   endproperty
   a_pair_quiet: assert property (p_pair_quiet) else $error("pair healthy levels misjudged"); // see RL3

   property p_pair_blocks_single;
      (pair_mode_select && !input_watchdog_bus_errors[SFS_INPUT_A_ERR_BIT] && !wr_errors)
         |=> !input_watchdog_bus_errors[SFS_INPUT_A_ERR_BIT];
   endproperty
   a_pair_blocks_single: assert property (p_pair_blocks_single) else $error("single error in pair mode"); // see RL4

   property p_mismatch_holds;
      (fault_input_config[SFS_POL_A_BIT] == fault_input_config_inv[SFS_POL_A_BIT])
         |=> input_a_polarity == $past(input_a_polarity);
   endproperty
   a_mismatch_holds: assert property (p_mismatch_holds) else $error("unmatched polarity applied"); // see RL5

   property p_match_applies;
      (fault_input_config[SFS_PAIR_MODE_BIT] != fault_input_config_inv[SFS_PAIR_MODE_BIT])
         |=> pair_mode_select == $past(fault_input_config[SFS_PAIR_MODE_BIT]);
   endproperty
   a_match_applies: assert property (p_match_applies) else $error("matched mode not applied"); // see RL5

   property p_wdog_timing;
      (WDOG_CLOSED_WRITE_I || WDOG_TIMEOUT_I) |=> input_watchdog_bus_errors[SFS_WDOG_TIMING_BIT];
   endproperty
   a_wdog_timing: assert property (p_wdog_timing) else $error("timing error lost"); // see RL6

   property p_wdog_answer;
      WDOG_BAD_ANSWER_I |=> input_watchdog_bus_errors[SFS_WDOG_ANSWER_BIT];
   endproperty
   a_wdog_answer: assert property (p_wdog_answer) else $error("answer error lost"); // see RL7

   property p_crc;
      BUS_CRC_ERR_I |=> input_watchdog_bus_errors[SFS_CRC_ERR_BIT];
   endproperty
   a_crc: assert property (p_crc) else $error("checksum error lost"); // see RL8

   property p_thermal_live;
      1'b1 |=> supply_fault_live[SFS_THERMAL_BIT] == $past(THERMAL_LIVE_I);
   endproperty
   a_thermal_live: assert property (p_thermal_live) else $error("live thermal bit wrong"); // see RL9

   property p_curlim_live;
      1'b1 |=> supply_fault_live[SFS_CURLIM_LSB +: SFS_REG_CNT] == $past(CURLIMIT_LIVE_I);
   endproperty
   a_curlim_live: assert property (p_curlim_live) else $error("live current limit wrong"); // see RL10

   property p_over_live;
      1'b1 |=> supply_fault_live[SFS_OV_LSB +: SFS_MON_CNT] == $past(OVER_LIVE_I);
   endproperty
   a_over_live: assert property (p_over_live) else $error("live overvoltage wrong"); // see RL11

   property p_latched_holds;
      !wr_supply |=> (supply_fault_latched & $past(supply_fault_latched)) == $past(supply_fault_latched);
   endproperty
   a_latched_holds: assert property (p_latched_holds) else $error("latched flag dropped"); // see RL12

   property p_under_latched;
      UNDER_LIVE_I[0] ##1 !wr_supply[*2] |=> supply_fault_latched[SFS_UV_LSB];
   endproperty
   a_under_latched: assert property (p_under_latched) else $error("undervoltage not latched"); // see RL13 see RL12

   // Opposite polarities of the single inputs, and the second pair polarity
   property p_input_a_high;
      (!pair_mode_select && input_a_polarity && FAULT_INPUT_A_I)
         |=> input_watchdog_bus_errors[SFS_INPUT_A_ERR_BIT];
   endproperty
   a_input_a_high: assert property (p_input_a_high) else $error("input a high fault not flagged"); // see RL1

   property p_input_b_low;
      (!pair_mode_select && !input_b_polarity && !FAULT_INPUT_B_I)
         |=> input_watchdog_bus_errors[SFS_INPUT_B_ERR_BIT];
   endproperty
   a_input_b_low: assert property (p_input_b_low) else $error("input b low fault not flagged"); // see RL2

   property p_pair_fault_inv;
      (pair_mode_select && pair_polarity && (FAULT_INPUT_A_I || !FAULT_INPUT_B_I))
         |=> input_watchdog_bus_errors[SFS_PAIR_ERR_BIT] && FAULT_ACTIVE_O;
   endproperty
   a_pair_fault_inv: assert property (p_pair_fault_inv) else $error("inverted pair fault not flagged"); // see RL3

   // Independent judging must never raise the pair flag
   property p_independent_no_pair;
      (!pair_mode_select && !input_watchdog_bus_errors[SFS_PAIR_ERR_BIT] && !wr_errors)
         |=> !input_watchdog_bus_errors[SFS_PAIR_ERR_BIT];
   endproperty
   a_independent_no_pair: assert property (p_independent_no_pair) else $error("pair error seen"); // see RL4

   // Undervoltage lanes and latching of every live lane
   property p_under_live;
      1'b1 |=> supply_fault_live[SFS_UV_LSB +: SFS_MON_CNT] == $past(UNDER_LIVE_I);
   endproperty
   a_under_live: assert property (p_under_live) else $error("live undervoltage wrong"); // see RL13

   property p_latched_sets;
      1'b1 |=> (supply_fault_latched & $past(live_now)) == $past(live_now);
   endproperty
   a_latched_sets: assert property (p_latched_sets) else $error("live condition not latched"); // see RL12

   // Error clear takes effect when no new event arrives with it
   property p_error_clears;
      (wr_errors && REG_WDATA_I[SFS_REQ_ERR_BIT] && !BUS_REQ_ERR_I)
         |=> !input_watchdog_bus_errors[SFS_REQ_ERR_BIT];
   endproperty
   a_error_clears: assert property (p_error_clears) else $error("request error not cleared");

   // Indicator must drop once every judged error is gone
   property p_fault_active_quiet;
      (!input_a_error && !input_b_error && !pair_error) |=> !FAULT_ACTIVE_O;
   endproperty
   a_fault_active_quiet: assert property (p_fault_active_quiet) else $error("fault indicator without error");

   // Read port: one valid pulse per read, data held between reads
   property p_read_pulse;
      REG_RD_I |=> REG_RVALID_O;
   endproperty
   a_read_pulse: assert property (p_read_pulse) else $error("read answer missing");

   property p_read_idle;
      !REG_RD_I |=> !REG_RVALID_O && $stable(REG_RDATA_O);
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("read port moved without read");

   c_pair_fault: cover property (pair_mode_select ##1 input_watchdog_bus_errors[SFS_PAIR_ERR_BIT]);
   c_clear_latched: cover property (supply_fault_latched != SFS_ZERO ##1 wr_supply ##1
                                    supply_fault_latched == SFS_ZERO);
   c_config_applied: cover property (wr_config ##2 wr_config_inv ##2 pair_mode_select);
   c_read: cover property (REG_RD_I ##1 REG_RVALID_O);
   c_single_fault: cover property (!pair_mode_select ##1 input_watchdog_bus_errors[SFS_INPUT_A_ERR_BIT]);

endmodule : sfs_status_bank

// ===== hdl/sfs_pkg.sv
package sfs_pkg;
   // Register indices on the register access port
   localparam logic [2:0] SFS_REG_SUPPLY_LATCHED = 3'h0;
   localparam logic [2:0] SFS_REG_SUPPLY_LIVE = 3'h1;
   localparam logic [2:0] SFS_REG_ERRORS = 3'h2;
   localparam logic [2:0] SFS_REG_CONFIG = 3'h3;
   localparam logic [2:0] SFS_REG_CONFIG_INV = 3'h4;

   localparam int SFS_DATA_W = 16;

   // Supply register layout, shared by the latched and live copies
   localparam int SFS_OV_LSB = 0;
   localparam int SFS_UV_LSB = 6;
   localparam int SFS_THERMAL_BIT = 12;
   localparam int SFS_CURLIM_LSB = 13;
   localparam int SFS_MON_CNT = 6;
   localparam int SFS_REG_CNT = 2;

   // Error register layout
   localparam int SFS_REQ_ERR_BIT = 0;
   localparam int SFS_CRC_ERR_BIT = 1;
   localparam int SFS_WDOG_ANSWER_BIT = 4;
   localparam int SFS_WDOG_TIMING_BIT = 5;
   localparam int SFS_ERR_MON_ONE_BIT = 8;
   localparam int SFS_ERR_MON_TWO_BIT = 9;
   localparam int SFS_PAIR_ERR_BIT = 12;
   localparam int SFS_INPUT_A_ERR_BIT = 13;
   localparam int SFS_INPUT_B_ERR_BIT = 14;

   // Fault input configuration layout
   localparam int SFS_PAIR_MODE_BIT = 8;
   localparam int SFS_POL_B_BIT = 12;
   localparam int SFS_POL_A_BIT = 13;
   localparam int SFS_PAIR_POL_BIT = 14;
   localparam logic [15:0] SFS_CONFIG_MASK = 16'h7100;

   // Reset values: configuration and its inverse agree from the start
   localparam logic [15:0] SFS_CONFIG_RESET = 16'h0000;
   localparam logic [15:0] SFS_CONFIG_INV_RESET = 16'h7100;
   localparam logic [15:0] SFS_ZERO = 16'h0000;
endpackage : sfs_pkg

// ===== verif/sfs_fault_src.sv
`timescale 1ns/1ns
module sfs_fault_src (
   input wire logic clk_i, // Bench clock
   input wire logic a_req_i, // Wanted level, input a
   input wire logic b_req_i, // Wanted level, input b
   output logic a_o, // Fault input a pin
   output logic b_o // Fault input b pin
);
   // Start low so the first judged edge after reset already sees a level
   initial begin
      a_o = 1'b0;
      b_o = 1'b0;
   end
   // Pins move off the sampling edge, as a push-pull output would
   always @(negedge clk_i) begin
      a_o <= a_req_i;
      b_o <= b_req_i;
   end
endmodule : sfs_fault_src

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench;
   import sfs_pkg::*;
   logic clk, rst, wr, rd, a_req, b_req, fa, fb, thermal, rvalid, factive;
   logic [2:0] addr;
   logic [15:0] wdata, rdata;
   logic [5:0] over, under;
   logic [1:0] curlim;
   logic [6:0] ev;
   int errors = 0;
   int cmp_count = 0;
   // Error bit set by each event line, same order as ev
   int ev_bit [7] = '{SFS_ERR_MON_ONE_BIT, SFS_ERR_MON_TWO_BIT, SFS_WDOG_TIMING_BIT, SFS_WDOG_TIMING_BIT,
      SFS_WDOG_ANSWER_BIT, SFS_CRC_ERR_BIT, SFS_REQ_ERR_BIT};
   sfs_fault_src mcu (.clk_i(clk), .a_req_i(a_req), .b_req_i(b_req), .a_o(fa), .b_o(fb));
   sfs_status_bank dut (.CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
      .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .FAULT_INPUT_A_I(fa), .FAULT_INPUT_B_I(fb),
      .OVER_LIVE_I(over), .UNDER_LIVE_I(under), .CURLIMIT_LIVE_I(curlim), .THERMAL_LIVE_I(thermal),
      .ERR_MON_ONE_I(ev[0]), .ERR_MON_TWO_I(ev[1]), .WDOG_CLOSED_WRITE_I(ev[2]), .WDOG_TIMEOUT_I(ev[3]),
      .WDOG_BAD_ANSWER_I(ev[4]), .BUS_CRC_ERR_I(ev[5]), .BUS_REQ_ERR_I(ev[6]), .FAULT_ACTIVE_O(factive));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   // Answer comes exactly one edge after the read is taken
   task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string what);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      chk({15'h0000, rvalid}, 16'h0001, "read valid");
      chk(rdata, exp, what);
   endtask : rd_chk
   task automatic set_pins(input logic a, input logic b);
      a_req = a;
      b_req = b;
      repeat (3) @(negedge clk);
   endtask : set_pins
   task automatic t_reset;
      rd_chk(SFS_REG_CONFIG, SFS_CONFIG_RESET, "config reset");
      rd_chk(SFS_REG_CONFIG_INV, SFS_CONFIG_INV_RESET, "inverse reset");
      rd_chk(SFS_REG_SUPPLY_LATCHED, 16'h0000, "latched reset");
      rd_chk(3'h5, 16'h0000, "unmapped read");
      rd_chk(SFS_REG_ERRORS, 16'h6000, "low pins fault");
      chk({15'h0000, factive}, 16'h0001, "fault active");
      $display("test reset done");
   endtask : t_reset
   task automatic t_supply;
      over = 6'h2a;
      under = 6'h15;
      curlim = 2'b10;
      thermal = 1'b1;
      repeat (2) @(negedge clk);
      over = 6'h00;
      under = 6'h00;
      curlim = 2'b00;
      thermal = 1'b0;
      rd_chk(SFS_REG_SUPPLY_LATCHED, 16'h556a, "latched kept");
      wr_reg(SFS_REG_SUPPLY_LATCHED, 16'h556a);
      rd_chk(SFS_REG_SUPPLY_LATCHED, 16'h0000, "latched cleared");
      over = 6'h15;
      under = 6'h2a;
      curlim = 2'b01;
      thermal = 1'b1;
      wr_reg(SFS_REG_SUPPLY_LIVE, 16'h0000);
      rd_chk(SFS_REG_SUPPLY_LIVE, 16'h3a95, "live bits");
      thermal = 1'b0;
      curlim = 2'b00;
      over = 6'h00;
      under = 6'h00;
      @(negedge clk);
      rd_chk(SFS_REG_SUPPLY_LIVE, 16'h0000, "live follow");
      $display("test supply done");
   endtask : t_supply
   task automatic t_events;
      set_pins(1'b1, 1'b1);
      wr_reg(SFS_REG_ERRORS, 16'hffff);
      rd_chk(SFS_REG_ERRORS, 16'h0000, "errors cleared");
      for (int k = 0; k < 7; k++) begin
         ev[k] = 1'b1;
         @(negedge clk);
         ev[k] = 1'b0;
         rd_chk(SFS_REG_ERRORS, 16'h0001 << ev_bit[k], "event flag");
         wr_reg(SFS_REG_ERRORS, 16'hffff);
      end
      $display("test events done");
   endtask : t_events
   task automatic t_polarity;
      wr_reg(SFS_REG_CONFIG, 16'h3000);
      wr_reg(SFS_REG_CONFIG_INV, 16'h4100);
      set_pins(1'b1, 1'b0);
      wr_reg(SFS_REG_ERRORS, 16'hffff);
      rd_chk(SFS_REG_ERRORS, 16'h2000, "high faults a");
      wr_reg(SFS_REG_CONFIG, 16'h0000);
      set_pins(1'b1, 1'b1);
      wr_reg(SFS_REG_ERRORS, 16'hffff);
      rd_chk(SFS_REG_ERRORS, 16'h6000, "mismatch kept");
      $display("test polarity done");
   endtask : t_polarity
   task automatic t_pair;
      wr_reg(SFS_REG_CONFIG, 16'h0100);
      wr_reg(SFS_REG_CONFIG_INV, 16'h7000);
      set_pins(1'b1, 1'b0);
      wr_reg(SFS_REG_ERRORS, 16'hffff);
      rd_chk(SFS_REG_ERRORS, 16'h0000, "pair healthy");
      chk({15'h0000, factive}, 16'h0000, "no fault");
      set_pins(1'b1, 1'b1);
      rd_chk(SFS_REG_ERRORS, 16'h1000, "pair b high");
      wr_reg(SFS_REG_CONFIG_INV, 16'h3000);
      wr_reg(SFS_REG_CONFIG, 16'h4100);
      set_pins(1'b0, 1'b1);
      wr_reg(SFS_REG_ERRORS, 16'hffff);
      rd_chk(SFS_REG_ERRORS, 16'h0000, "pair inverted ok");
      set_pins(1'b1, 1'b0);
      chk({15'h0000, factive}, 16'h0001, "pair inverted fault");
      $display("test pair done");
   endtask : t_pair
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence, inputs all move on the falling edge
   initial begin
      {rst, wr, rd, a_req, b_req, thermal} = 6'b100000;
      {over, under, curlim, ev} = 21'h000000;
      addr = 3'h0;
      wdata = 16'h0000;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_supply();
      t_events();
      t_polarity();
      t_pair();
      report_and_stop();
   end
endmodule : testbench
